// File: hw/lgc_pkg.sv
// lgc_pkg: constants and types of the legacy dma, timer and interrupt block
// assumes one 100 MHz system clock and a 16-bit register port
`default_nettype none
package lgc_pkg;
  localparam int AW  = 6;
  localparam int DW  = 16;
  localparam int NCH = 8;
  localparam int NTM = 3;
  localparam int MW  = 4;

  // register offsets; groups of eight hold one word per channel
  localparam logic [AW-1:0] A_ADDR = 6'h00;
  localparam logic [AW-1:0] A_CNT  = 6'h08;
  localparam logic [AW-1:0] A_MODE = 6'h10;
  localparam logic [AW-1:0] A_DCTL = 6'h18;
  localparam logic [AW-1:0] A_DSTS = 6'h19;
  localparam logic [AW-1:0] A_TRLD = 6'h1A;
  localparam logic [AW-1:0] A_TCTL = 6'h1D;
  localparam logic [AW-1:0] A_ISTS = 6'h1E;
  localparam logic [AW-1:0] A_IMSK = 6'h1F;
  localparam logic [AW-1:0] A_IVEC = 6'h20;

  // channel mode word: [1:0] type, [2] decrement, [3] fast type-F
  localparam logic [1:0] MD_SINGLE = 2'h0;
  localparam logic [1:0] MD_DEMAND = 2'h1;
  localparam logic [1:0] MD_VERIFY = 2'h2;
  localparam int MB_DEC  = 2;
  localparam int MB_FAST = 3;
  localparam logic [3:0] FAST_MAX = 4'h2;

  // dma control bits
  localparam int CB_EN  = 0;
  localparam int CB_ROT = 1;

  localparam logic [2:0] CH_BM = 3'h4;
  localparam logic [2:0] CH_W0 = 3'h5;
  localparam logic [2:0] CAS_IN = 3'h2;
  localparam logic [DW-1:0] STEP_B = 16'h0001;
  localparam logic [DW-1:0] STEP_W = 16'h0002;
  localparam logic [DW-1:0] ONE    = 16'h0001;
  localparam logic [DW-1:0] ZERO   = 16'h0000;

  // interrupt lines: 0 timer, 2 dma terminal count, the rest external
  localparam int IRQ_TMR = 0;
  localparam int IRQ_DMA = 2;
  localparam logic [15:0] EXT_MASK = 16'hFFFA;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [3:0]  SLOT_LAST = 4'hF;
  localparam logic [3:0]  SLV_BASE  = 4'h8;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_XFER = 3'b010,
    D_BM   = 3'b100
  } lgc_dst_t;

  typedef struct packed {
    logic          stb;
    logic          verify;
    logic          word;
    logic          tc;
    logic [DW-1:0] addr;
  } lgc_dout_t;

  typedef struct packed {
    logic [NCH-1:0][DW-1:0] dma_addr;
    logic [NCH-1:0][DW-1:0] dma_cnt;
    logic [NCH-1:0][MW-1:0] dma_mode;
    logic [1:0]             dctl;
    logic [NCH-1:0]         dsts;
    lgc_dst_t               st;
    logic [2:0]             cur;
    logic [2:0]             rot;
    logic                   ph;
    lgc_dout_t              dout;
    logic [NTM-1:0][DW-1:0] tmr_rld;
    logic [NTM-1:0][DW-1:0] tmr_cnt;
    logic [NTM-1:0]         tmr_out;
    logic [NTM-1:0]         tctl;
    logic                   osc_q;
    logic [15:0]            irq_q;
    logic [3:0]             sirq_slot;
    logic                   sirq_act;
    logic [15:0]            ists;
    logic [15:0]            imsk;
    logic [DW-1:0]          rdata;
  } lgc_st_t;
endpackage
`default_nettype wire

// File: hw/lgc_top.sv
// lgc_top: seven-channel dma, three-counter timer and cascaded interrupt block
// assumes request lines already decoded from the lpc and pc/pci front ends,
// oscillator and serial-interrupt inputs synchronous to MCLK
//
// Functional notes
// - seven programmable dma channels built as one eight-channel controller
// - channels 0-3 move bytes; count drops once per byte
// - channels 5-7 move words; count drops once per word
// - at most two channels may hold the fast type-F timing bit
// - lpc and pc/pci requests share the one dma controller
// - pc/pci peripherals use encoded request/grant pairs for dma
// - lpc peripherals request with their request line; host answers on lad
// - single, demand, verify and increment modes are supported
// - channel 4 moves no data; it is a bus master request
// - three interval counters give system timer and speaker tone
// - timer counters run off the oscillator input, not the bus clock
// - cascaded controllers give 14 external and two internal interrupts
// - interrupts may also arrive through a serial interrupt frame
// - every register reads back for state save and restore
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module lgc_top
  import lgc_pkg::*;
(
  input  wire logic                  MCLK,
  input  wire logic                  RSTN,
  input  wire logic [lgc_pkg::AW-1:0] ADDR,
  input  wire logic [lgc_pkg::DW-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [lgc_pkg::DW-1:0] RDATA,
  input  wire logic [7:0]            LPC_DREQ,
  input  wire logic [7:0]            PCI_DREQ,
  output logic      [7:0]            DMA_ACK,
  output lgc_pkg::lgc_dout_t         DMA_OUT,
  output logic                       BM_GNT,
  input  wire logic                  OSC_IN,
  output logic                       SPKR_OUT,
  input  wire logic [15:0]           IRQ_IN,
  input  wire logic                  SIRQ_START,
  input  wire logic                  SIRQ_DATA_N,
  output logic                       INTR
);
  import lgc_pkg::*;

  lgc_st_t       s;
  lgc_st_t       next_s;
  logic [7:0]    req;
  logic          tick;
  logic [3:0]    k;
  logic [15:0]   rr;
  logic [3:0]    pk;
  logic [2:0]    ch;
  logic [MW-1:0] md;
  logic          wd;
  logic [DW-1:0] step;
  logic [15:0]   clr;
  logic [15:0]   ev;
  logic [7:0]    dclr;
  logic [7:0]    mv;
  logic [3:0]    mp;
  logic [3:0]    sp;
  logic [4:0]    vec;

  // lowest set bit: {found, index}
  function automatic logic [3:0] first(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] nfast(input logic [NCH-1:0][MW-1:0] m,
                                       input logic [2:0] skip);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NCH; i++) begin
      if (m[i][MB_FAST] && 3'(i) != skip) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  always_comb begin
    next_s = s;
    req    = LPC_DREQ | PCI_DREQ;
    tick   = OSC_IN & ~s.osc_q;
    next_s.osc_q = OSC_IN;
    next_s.rdata = ZERO;
    next_s.dout.stb    = 1'b0;
    next_s.dout.tc     = 1'b0;
    next_s.dout.verify = 1'b0;
    k    = 4'h0;
    rr   = 16'h0000;
    pk   = 4'h0;
    ch   = 3'h0;
    md   = s.dma_mode[s.cur];
    wd   = s.cur >= CH_W0;
    step = wd ? STEP_W : STEP_B;
    clr  = 16'h0000;
    dclr = 8'h00;
    ev   = 16'h0000;

    // software writes; hardware updates below take precedence
    if (WR) begin
      if (ADDR[5:3] == A_ADDR[5:3]) next_s.dma_addr[ADDR[2:0]] = WDATA;
      if (ADDR[5:3] == A_CNT[5:3]) next_s.dma_cnt[ADDR[2:0]] = WDATA;
      if (ADDR[5:3] == A_MODE[5:3]) begin
        next_s.dma_mode[ADDR[2:0]] = WDATA[MW-1:0];
        // a third fast request is dropped, the rest of the mode kept
        if (nfast(s.dma_mode, ADDR[2:0]) >= FAST_MAX) begin
          next_s.dma_mode[ADDR[2:0]][MB_FAST] = 1'b0;
        end
      end
      if (ADDR == A_DCTL) next_s.dctl = WDATA[1:0];
      if (ADDR == A_DSTS) dclr = WDATA[7:0];
      if (ADDR == A_TCTL) next_s.tctl = WDATA[NTM-1:0];
      if (ADDR == A_ISTS) clr = WDATA;
      if (ADDR == A_IMSK) next_s.imsk = WDATA;
      for (int i = 0; i < NTM; i++) begin
        if (ADDR == A_TRLD + AW'(i)) begin
          next_s.tmr_rld[i] = WDATA;
          next_s.tmr_cnt[i] = WDATA;
        end
      end
    end
    next_s.dsts = s.dsts & ~dclr;

    // dma engine
    case (s.st)
      D_IDLE: begin
        if (s.dctl[CB_EN] && |req) begin
          // rotating: window starts past the last grant, so that channel comes last
          k  = s.dctl[CB_ROT] ? 4'({1'b0, s.rot} + 4'h1) : 4'h0;
          rr = 16'({req, req} >> k);
          pk = first(rr[7:0]);
          ch = pk[2:0] + k[2:0];
          next_s.cur = ch;
          next_s.rot = ch;
          next_s.ph  = 1'b0;
          next_s.st  = (ch == CH_BM) ? D_BM : D_XFER;
        end
      end
      D_XFER: begin
        // compatible timing spends a wait cycle per transfer
        if (!md[MB_FAST] && !s.ph) begin
          next_s.ph = 1'b1;
        end else begin
          next_s.ph = 1'b0;
          next_s.dout.stb    = 1'b1;
          next_s.dout.verify = md[1:0] == MD_VERIFY;
          next_s.dout.word   = wd;
          next_s.dout.addr   = s.dma_addr[s.cur];
          next_s.dma_addr[s.cur] = md[MB_DEC] ? s.dma_addr[s.cur] - step
                                              : s.dma_addr[s.cur] + step;
          next_s.dma_cnt[s.cur]  = s.dma_cnt[s.cur] - ONE;
          if (s.dma_cnt[s.cur] == ZERO) begin
            next_s.dout.tc = 1'b1;
            next_s.dsts[s.cur] = 1'b1;
            ev[IRQ_DMA] = 1'b1;
            next_s.st = D_IDLE;
          end else if (md[1:0] == MD_SINGLE || !req[s.cur]) begin
            next_s.st = D_IDLE;
          end
        end
      end
      D_BM: begin
        if (!req[CH_BM]) next_s.st = D_IDLE;
      end
      default: next_s.st = D_IDLE;
    endcase

    // interval counters, square wave on each output
    // a reload of one toggles the output on every rising oscillator edge
    for (int i = 0; i < NTM; i++) begin
      if (s.tctl[i] && tick) begin
        if (s.tmr_cnt[i] <= ONE) begin
          next_s.tmr_cnt[i] = s.tmr_rld[i];
          next_s.tmr_out[i] = ~s.tmr_out[i];
        end else begin
          next_s.tmr_cnt[i] = s.tmr_cnt[i] - ONE;
        end
      end
    end
    ev[IRQ_TMR] = next_s.tmr_out[0] & ~s.tmr_out[0];

    // dedicated lines are edge sensitive
    next_s.irq_q = IRQ_IN;
    ev = ev | (IRQ_IN & ~s.irq_q & EXT_MASK);

    // serial frame: one slot per clock after the start pulse
    if (SIRQ_START) begin
      next_s.sirq_act  = 1'b1;
      next_s.sirq_slot = 4'h0;
    end else if (s.sirq_act) begin
      if (!SIRQ_DATA_N && EXT_MASK[s.sirq_slot]) ev[s.sirq_slot] = 1'b1;
      next_s.sirq_slot = s.sirq_slot + 4'h1;
      if (s.sirq_slot == SLOT_LAST) next_s.sirq_act = 1'b0;
    end
    next_s.ists = (s.ists & ~clr) | ev;

    // slave summary rides on the master's cascade input
    mv = s.ists[7:0] & ~s.imsk[7:0];
    mv[CAS_IN] = |(s.ists[15:8] & ~s.imsk[15:8]);
    mp = first(mv);
    sp = first(s.ists[15:8] & ~s.imsk[15:8]);
    // vector bit 4 flags a pending line; slave lines land on 8-15
    vec = {mp[3], mp[2:0] == CAS_IN ? SLV_BASE + {1'b0, sp[2:0]} : {1'b0, mp[2:0]}};

    // every register reads back
    if (RD) begin
      if (ADDR[5:3] == A_ADDR[5:3]) next_s.rdata = s.dma_addr[ADDR[2:0]];
      if (ADDR[5:3] == A_CNT[5:3]) next_s.rdata = s.dma_cnt[ADDR[2:0]];
      if (ADDR[5:3] == A_MODE[5:3]) next_s.rdata = DW'(s.dma_mode[ADDR[2:0]]);
      if (ADDR == A_DCTL) next_s.rdata = DW'(s.dctl);
      if (ADDR == A_DSTS) next_s.rdata = DW'(s.dsts);
      if (ADDR == A_TCTL) next_s.rdata = DW'(s.tctl);
      if (ADDR == A_ISTS) next_s.rdata = s.ists;
      if (ADDR == A_IMSK) next_s.rdata = s.imsk;
      if (ADDR == A_IVEC) next_s.rdata = DW'(vec);
      for (int i = 0; i < NTM; i++) begin
        if (ADDR == A_TRLD + AW'(i)) next_s.rdata = s.tmr_rld[i];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      s      <= '0;
      s.st   <= D_IDLE;
      // all lines masked so nothing interrupts before software is ready
      s.imsk <= RST_MASK;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA    = s.rdata;
  assign DMA_OUT  = s.dout;
  // grant follows the state register, so it drops with the last strobe
  assign DMA_ACK  = (s.st == D_XFER) ? (8'h01 << s.cur) : 8'h00;
  assign BM_GNT   = s.st == D_BM;
  assign SPKR_OUT = s.tmr_out[2];
  assign INTR     = |(s.ists & ~s.imsk);

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_ack_onehot: assert property ($onehot0(DMA_ACK) && !(BM_GNT && |DMA_ACK))
    else $error("more than one dma grant");
  a_addr_step: assert property (DMA_OUT.stb && !s.dma_mode[s.cur][MB_DEC]
    |-> s.dma_addr[s.cur] == DMA_OUT.addr + (DMA_OUT.word ? STEP_W : STEP_B))
    else $error("address step wrong");
  a_word_wide: assert property (DMA_OUT.stb |-> DMA_OUT.word == (s.cur >= CH_W0))
    else $error("transfer width wrong");
  a_fast_limit: assert property (nfast(s.dma_mode, CH_BM) + 4'(s.dma_mode[CH_BM][MB_FAST])
    <= FAST_MAX)
    else $error("too many fast channels");
  a_req_taken: assert property (s.st == D_IDLE && s.dctl[CB_EN] && |(LPC_DREQ | PCI_DREQ)
    |=> s.st != D_IDLE)
    else $error("request not taken");
  a_single_stop: assert property (DMA_OUT.stb && s.dma_mode[s.cur][1:0] == MD_SINGLE
    |-> s.st == D_IDLE)
    else $error("single mode kept the bus");
  a_ch4_nodata: assert property (DMA_OUT.stb |-> s.cur != CH_BM && !BM_GNT)
    else $error("channel 4 moved data");
  a_tmr_reload: assert property (tick && !WR && s.tctl[0] && s.tmr_cnt[0] <= ONE
    |=> s.tmr_cnt[0] == $past(s.tmr_rld[0]) && s.tmr_out[0] != $past(s.tmr_out[0]))
    else $error("timer reload wrong");
  a_tmr_hold: assert property (!tick && !WR |=> $stable(s.tmr_cnt))
    else $error("timer moved without oscillator edge");
  a_irq_sticky: assert property (1'b1 |=> (~$past(clr) & $past(s.ists) & ~s.ists) == 16'h0000)
    else $error("status bit lost");
  a_serial_set: assert property (s.sirq_act && !SIRQ_START && !SIRQ_DATA_N
    && EXT_MASK[s.sirq_slot] |=> s.ists[$past(s.sirq_slot)])
    else $error("serial interrupt missed");
  a_mask_back: assert property (WR && ADDR == A_IMSK ##1 RD && !WR && ADDR == A_IMSK
    |=> RDATA == $past(WDATA, 2))
    else $error("mask readback wrong");
  a_fixed_prio: assert property (s.st == D_IDLE && s.dctl[CB_EN] && !s.dctl[CB_ROT]
    && (LPC_DREQ[0] | PCI_DREQ[0]) |=> s.cur == 3'h0)
    else $error("fixed priority violated");
  a_rot_prio: assert property (s.st == D_IDLE && s.dctl[CB_EN] && s.dctl[CB_ROT]
    && |(LPC_DREQ | PCI_DREQ) && (LPC_DREQ | PCI_DREQ) != (8'h01 << s.rot)
    |=> s.cur != $past(s.rot))
    else $error("rotating priority violated");
  a_tc_wrap: assert property (DMA_OUT.tc |-> DMA_OUT.stb && s.dma_cnt[s.cur] == ~ZERO)
    else $error("count did not wrap at terminal count");
  a_bm_hold: assert property (BM_GNT && (LPC_DREQ[CH_BM] | PCI_DREQ[CH_BM]) |=> BM_GNT)
    else $error("bus master grant dropped");

  c_tc: cover property (DMA_OUT.tc);
  c_bm: cover property (BM_GNT ##1 !BM_GNT);
  c_rot: cover property (s.dctl[CB_ROT] && DMA_OUT.stb);
  c_verify: cover property (DMA_OUT.stb && DMA_OUT.verify);
  c_sirq: cover property (SIRQ_START ##1 s.sirq_act ##[1:16] INTR);
endmodule // lgc_top
`default_nettype wire

// File: test/lgc_periph_model.sv
// lgc_periph_model: lpc and pc/pci peripherals asking for dma service
// assumes decoded per-channel request levels and the block's ack and tc outputs
`timescale 1ns/100ps
`default_nettype none
module lgc_periph_model (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic [7:0]         req_set,
  input  wire logic [7:0]         req_clr,
  input  wire logic [7:0]         via_pci,
  input  wire logic               slow,
  input  wire logic [7:0]         ack,
  input  wire lgc_pkg::lgc_dout_t dout,
  output logic      [7:0]         lpc_req,
  output logic      [7:0]         pci_req
);
  import lgc_pkg::*;
  logic [7:0] pending;
  logic [7:0] set_q;
  logic [7:0] last_ack;
  logic [7:0] done;
  // ack may already be gone when tc shows, so the last granted channel is kept
  assign done    = dout.tc ? last_ack : 8'h00;
  assign lpc_req = pending & ~done & ~via_pci;
  assign pci_req = pending & ~done & via_pci;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pending  <= 8'h00;
      set_q    <= 8'h00;
      last_ack <= 8'h00;
    end else begin
      set_q   <= req_set;
      pending <= (pending | (slow ? set_q : req_set)) & ~req_clr & ~done;
      if (ack != 8'h00) begin
        last_ack <= ack;
      end
    end
  end
endmodule // lgc_periph_model
`default_nettype wire

// File: test/lgc_top_tb.sv
// lgc_top_tb: register, dma, timer and interrupt tests of lgc_top
// assumes lgc_periph_model as the requesting peripherals
`timescale 1ns/100ps
`default_nettype none
module lgc_top_tb;
  import lgc_pkg::*;
  logic          mclk, rstn, wr, rd, bm_gnt, osc, spkr, sirq_start, sirq_n, intr, slow;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [7:0]    lpc_req, pci_req, ack, req_set, req_clr, via_pci, ack_seen;
  logic [15:0]   irq_in;
  lgc_dout_t     dout;
  logic [18:0]   xlog[$];
  int            n_errors;
  int            total_checks;

  lgc_top i_dut (.MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LPC_DREQ(lpc_req), .PCI_DREQ(pci_req), .DMA_ACK(ack), .DMA_OUT(dout),
    .BM_GNT(bm_gnt), .OSC_IN(osc), .SPKR_OUT(spkr), .IRQ_IN(irq_in),
    .SIRQ_START(sirq_start), .SIRQ_DATA_N(sirq_n), .INTR(intr));
  lgc_periph_model i_per (.mclk(mclk), .rstn(rstn), .req_set(req_set), .req_clr(req_clr),
    .via_pci(via_pci), .slow(slow), .ack(ack), .dout(dout), .lpc_req(lpc_req),
    .pci_req(pci_req));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // transfers logged as {tc, word, verify, addr}, taken on the settled half
  always @(negedge mclk) begin
    if (dout.stb === 1'b1) begin
      xlog.push_back({dout.tc, dout.word, dout.verify, dout.addr});
    end
  end
  // every channel granted so far, so a stray grant shows
  always @(negedge mclk) begin
    if (!rstn) begin
      ack_seen <= 8'h00;
    end else begin
      ack_seen <= ack_seen | ack;
    end
  end

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk({16'h0000, rdata}, {16'h0000, exp});
  endtask
  task automatic request(input logic [7:0] s);
    @(posedge mclk);
    req_set <= s;
    @(posedge mclk);
    req_set <= 8'h00;
  endtask
  task automatic wait_xfers(input int n);
    for (int i = 0; i < 400 && xlog.size() < n; i++) begin
      @(posedge mclk);
    end
    ticks(10);
    chk(32'(xlog.size()), 32'(n));
  endtask
  task automatic pop_chk(input logic [18:0] exp);
    logic [18:0] got;
    got = (xlog.size() > 0) ? xlog.pop_front() : 19'h7FFFF;
    chk({13'h0000, got}, {13'h0000, exp});
  endtask
  task automatic osc_pulses(input int n);
    repeat (n) begin
      osc <= 1'b1;
      ticks(4);
      osc <= 1'b0;
      ticks(3);
    end
  endtask

  initial begin
    {rstn, wr, rd, osc, sirq_start, slow} = 6'h00;
    sirq_n = 1'b1;
    {addr, wdata, irq_in} = '0;
    {req_set, req_clr, via_pci} = '0;
    ticks(12);
    rstn <= 1'b1;
    rd_chk(A_IMSK, 16'hFFFF);
    chk({31'h0, intr}, 32'h0);
    wr_reg(A_ADDR + 6'h07, 16'h5A5A);
    rd_chk(A_ADDR + 6'h07, 16'h5A5A);
    wr_reg(A_CNT + 6'h06, 16'hA5C3);
    rd_chk(A_CNT + 6'h06, 16'hA5C3);
    wr_reg(A_TRLD + 6'h01, 16'h1234);
    rd_chk(A_TRLD + 6'h01, 16'h1234);
    rd_chk(6'h3F, 16'h0000);
    $display("test registers done");
    // a third fast channel is refused, the fast bit is dropped
    wr_reg(A_MODE, 16'h0008);
    wr_reg(A_MODE + 6'h01, 16'h0009);
    wr_reg(A_MODE + 6'h02, 16'h0008);
    rd_chk(A_MODE + 6'h02, 16'h0000);
    rd_chk(A_MODE, 16'h0008);
    $display("test fast limit done");
    wr_reg(A_ADDR + 6'h01, 16'h0100);
    wr_reg(A_CNT + 6'h01, 16'h0002);
    wr_reg(A_ADDR + 6'h03, 16'h0300);
    wr_reg(A_CNT + 6'h03, 16'h0000);
    wr_reg(A_MODE + 6'h03, {14'h0000, MD_VERIFY});
    via_pci <= 8'h08;
    wr_reg(A_DCTL, 16'h0001);
    request(8'h0A);
    wait_xfers(4);
    pop_chk(19'h00100);
    pop_chk(19'h00101);
    pop_chk(19'h40102);
    pop_chk(19'h50300);
    rd_chk(A_CNT + 6'h01, 16'hFFFF);
    rd_chk(A_DSTS, 16'h000A);
    chk({24'h0, ack_seen}, 32'h0A);
    $display("test byte channels done");
    wr_reg(A_ADDR + 6'h05, 16'h0200);
    wr_reg(A_CNT + 6'h05, 16'h0001);
    wr_reg(A_MODE + 6'h05, 16'h0004);
    slow <= 1'b1;
    request(8'h20);
    wait_xfers(2);
    pop_chk(19'h20200);
    pop_chk(19'h601FE);
    chk({24'h0, ack_seen}, 32'h2A);
    $display("test word channel done");
    request(8'h10);
    ticks(6);
    chk({31'h0, bm_gnt}, 32'h1);
    chk(32'(xlog.size()), 32'h0);
    chk({24'h0, ack}, 32'h0);
    req_clr <= 8'h10;
    ticks(1);
    req_clr <= 8'h00;
    ticks(4);
    chk({31'h0, bm_gnt}, 32'h0);
    chk({24'h0, ack_seen}, 32'h2A);
    $display("test bus master done");
    wr_reg(A_ISTS, 16'hFFFF);
    wr_reg(A_TRLD, 16'h0001);
    wr_reg(A_TRLD + 6'h02, 16'h0002);
    wr_reg(A_TCTL, 16'h0005);
    osc_pulses(2);
    chk({31'h0, spkr}, 32'h1);
    rd_chk(A_ISTS, 16'h0001);
    osc_pulses(2);
    chk({31'h0, spkr}, 32'h0);
    wr_reg(A_TCTL, 16'h0000);
    $display("test timer done");
    wr_reg(A_ISTS, 16'hFFFF);
    wr_reg(A_IMSK, 16'hFFDF);
    irq_in <= 16'h0020;
    ticks(4);
    chk({31'h0, intr}, 32'h1);
    rd_chk(A_IVEC, 16'h0015);
    wr_reg(A_ISTS, 16'h0020);
    ticks(2);
    chk({31'h0, intr}, 32'h0);
    irq_in <= 16'h0220;
    ticks(4);
    chk({31'h0, intr}, 32'h0);
    rd_chk(A_ISTS, 16'h0200);
    wr_reg(A_IMSK, 16'hFDFF);
    rd_chk(A_IVEC, 16'h0019);
    chk({31'h0, intr}, 32'h1);
    wr_reg(A_IMSK, 16'hFFFF);
    wr_reg(A_ISTS, 16'hFFFF);
    $display("test interrupts done");
    @(posedge mclk);
    sirq_start <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk);
      sirq_start <= 1'b0;
      sirq_n     <= (k != 11);
    end
    @(posedge mclk);
    sirq_n <= 1'b1;
    ticks(2);
    rd_chk(A_ISTS, 16'h0800);
    wr_reg(A_IMSK, 16'hF7FF);
    ticks(1);
    chk({31'h0, intr}, 32'h1);
    $display("test serial interrupt done");
    wr_reg(A_ADDR, 16'h0010);
    request(8'h01);
    wait_xfers(1);
    pop_chk(19'h40010);
    wr_reg(A_CNT, 16'h0000);
    wr_reg(A_ADDR + 6'h02, 16'h0020);
    wr_reg(A_DCTL, 16'h0003);
    rd_chk(A_DCTL, 16'h0003);
    request(8'h05);
    wait_xfers(2);
    pop_chk(19'h40020);
    pop_chk(19'h40011);
    chk({24'h0, ack_seen}, 32'h2F);
    $display("test priority done");
    // write and read strobes back to back
    @(posedge mclk);
    addr  <= A_IMSK;
    wdata <= 16'h00F0;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk({16'h0000, rdata}, 32'h000000F0);
    ticks(2);
    rstn <= 1'b0;
    ticks(3);
    rstn <= 1'b1;
    rd_chk(A_IMSK, 16'hFFFF);
    rd_chk(A_DCTL, 16'h0000);
    rd_chk(A_ADDR, 16'h0000);
    chk({30'h0, intr, bm_gnt}, 32'h0);
    $display("test reset done");
    tally_and_finish;
  end

  initial begin
    ticks(20000);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule // lgc_top_tb
`default_nettype wire
